//--- logic/iesr_consts.svh
// Register map, field positions, reset values and timing counts
`ifndef IESR_CONSTS_SVH
`define IESR_CONSTS_SVH
`define IESR_OFF_CTRL   8'h00
`define IESR_OFF_STAT   8'h04
`define IESR_OFF_TXD    8'h08
`define IESR_OFF_RXD    8'h0c
`define IESR_OFF_IST    8'h10
`define IESR_OFF_IMSK   8'h14
`define IESR_CTRL_HOST  0
`define IESR_CTRL_START 1
`define IESR_CTRL_STOP  2
`define IESR_CTRL_EN    15
`define IESR_ST_BUSY    0
`define IESR_ST_RXF     1
`define IESR_ST_S       3
`define IESR_ST_P       4
`define IESR_ST_HALT    5
`define IESR_ST_NACK    6
`define IESR_ST_BCL     10
`define IESR_ST_OV      20
`define IESR_IRQ_BCL    0
`define IESR_IRQ_OV     1
`define IESR_IRQ_RX     2
`define IESR_IRQ_HALT   3
`define IESR_RST_WORD   32'h0000_0000
`define IESR_CLK_NS     40
`define IESR_HALF_NS    5000
`define IESR_HALF_CYC   ((`IESR_HALF_NS + `IESR_CLK_NS - 1) / `IESR_CLK_NS)
`define IESR_STRETCH_NS 1000000
`endif

//--- logic/iesr_pkg.sv
// Types shared by the two-wire error and recovery controller
package iesr_pkg;
    typedef struct packed {
        logic scl;
        logic sda;
    } iesr_pins_t;
    typedef enum logic [2:0] {
        ENG_IDLE  = 3'b000,
        ENG_START = 3'b001,
        ENG_HOLD  = 3'b010,
        ENG_LOW   = 3'b011,
        ENG_HIGH  = 3'b100,
        ENG_STOP  = 3'b101,
        ENG_STOPH = 3'b110
    } iesr_eng_t;
endpackage

//--- logic/iesr_ctrl.sv
// Two-wire bus controller with error flags, recovery and APB registers
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "iesr_consts.svh"

// Behaviour
// - Host mode sets collision flag, status bit 10
// - Late unread byte sets overflow flag bit 20
// - Start flag bit 3, stop flag bit 4
// - Free bus: accept new start, generate it
// - Reading the data register resumes reception; overflow need not be cleared
// - Enable low stops, clears status within 4 cycles
// - Enable high resumes from cleared status
// - No false errors at speed or long runs
// - A transfer halted by stretch timeout or collision shows in status
module iesr_ctrl #(
    parameter int STRETCH_CYC = `IESR_STRETCH_NS / `IESR_CLK_NS
) (
    input  wire logic                REF_CLK,
    input  wire logic                RST,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [7:0]          PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire iesr_pkg::iesr_pins_t LINK_IN,
    output iesr_pkg::iesr_pins_t     LINK_OUT,
    output iesr_pkg::iesr_pins_t     LINK_OE,
    output logic                     IRQ
);
    import iesr_pkg::*;

    localparam logic [15:0] HALF_LAST = 16'(`IESR_HALF_CYC - 1);
    localparam logic [15:0] ST_LAST   = 16'(STRETCH_CYC - 1);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Lines pass two flops before use; the third is the edge history.
    iesr_pins_t s1_q, s2_q, s3_q;
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= LINK_IN;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    logic start_ev, stop_ev, scl_rise;
    assign start_ev = s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
    assign stop_ev  = s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;
    assign scl_rise = s2_q.scl & ~s3_q.scl;

    // ----------------------------------------
    // State
    // ----------------------------------------
    iesr_eng_t   eng_q, eng_d;
    logic        en_q, en_d, host_q, host_d, spend_q, spend_d, ppend_q, ppend_d;
    logic        tpend_q, tpend_d, s_q, s_d, p_q, p_d, bcl_q, bcl_d, ov_q, ov_d;
    logic        halt_q, halt_d, nack_q, nack_d, rxf_q, rxf_d;
    logic [7:0]  txb_q, txb_d, sh_q, sh_d, rsh_q, rsh_d, rxb_q, rxb_d;
    logic [3:0]  bit_q, bit_d, rbit_q, rbit_d, ist_q, ist_d, imsk_q, imsk_d;
    logic [15:0] cnt_q, cnt_d, st_q, st_d;
    logic [31:0] prd_d;
    iesr_pins_t  oe_q, oe_d;
    logic        wr, rd, hit, bcl_set, ov_set, rx_set, halt_set;

    assign wr = PSEL & PENABLE & PWRITE;
    assign rd = PSEL & PENABLE & ~PWRITE;
    assign hit = PADDR inside {`IESR_OFF_CTRL, `IESR_OFF_STAT, `IESR_OFF_TXD,
                               `IESR_OFF_RXD, `IESR_OFF_IST, `IESR_OFF_IMSK};

    function automatic iesr_pins_t drive(iesr_eng_t e, logic [3:0] b, logic [7:0] s);
        iesr_pins_t p;
        p.scl = e inside {ENG_HOLD, ENG_LOW, ENG_STOP};
        p.sda = e inside {ENG_START, ENG_HOLD, ENG_STOP, ENG_STOPH}
              || (e inside {ENG_LOW, ENG_HIGH} && b < 4'd8 && !s[7]);
        return p;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        eng_d = eng_q;   en_d = en_q;     host_d = host_q; spend_d = spend_q;
        ppend_d = ppend_q; tpend_d = tpend_q; txb_d = txb_q; sh_d = sh_q;
        bit_d = bit_q;   cnt_d = cnt_q;   st_d = st_q;     nack_d = nack_q;
        rsh_d = rsh_q;   rbit_d = rbit_q; rxb_d = rxb_q;   imsk_d = imsk_q;
        bcl_set = 1'b0;  ov_set = 1'b0;   rx_set = 1'b0;   halt_set = 1'b0;
        if (wr && PADDR == `IESR_OFF_CTRL) begin
            en_d    = PWDATA[`IESR_CTRL_EN];
            host_d  = PWDATA[`IESR_CTRL_HOST];
            spend_d = spend_q | PWDATA[`IESR_CTRL_START];
            ppend_d = ppend_q | PWDATA[`IESR_CTRL_STOP];
        end
        if (wr && PADDR == `IESR_OFF_TXD) begin
            tpend_d = 1'b1;
            txb_d   = PWDATA[7:0];
        end
        if (wr && PADDR == `IESR_OFF_IMSK)
            imsk_d = PWDATA[3:0];
        // Host engine
        unique case (eng_q)
            ENG_IDLE: begin
                if (spend_q && host_q) begin
                    spend_d = 1'b0;
                    if (s_q) bcl_set = 1'b1;
                    else begin
                        eng_d = ENG_START;
                        cnt_d = '0;
                    end
                end
            end
            ENG_START, ENG_LOW, ENG_STOP, ENG_STOPH: begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == HALF_LAST) begin
                    cnt_d = '0;
                    eng_d = eng_q == ENG_START ? ENG_HOLD :
                            eng_q == ENG_LOW   ? ENG_HIGH :
                            eng_q == ENG_STOP  ? ENG_STOPH : ENG_IDLE;
                end
            end
            ENG_HOLD: begin
                cnt_d = '0;
                if (tpend_q) begin
                    tpend_d = 1'b0;
                    sh_d    = txb_q;
                    bit_d   = '0;
                    eng_d   = ENG_LOW;
                end else if (ppend_q) begin
                    ppend_d = 1'b0;
                    eng_d   = ENG_STOP;
                end
            end
            ENG_HIGH: begin
                if (!s2_q.scl) begin
                    // A client may stretch; too long is reported, never silent
                    st_d = st_q + 16'h0001;
                    if (st_q == ST_LAST) begin
                        halt_set = 1'b1;
                        eng_d    = ENG_IDLE;
                    end
                end else if (bit_q < 4'd8 && sh_q[7] && !s2_q.sda) begin
                    bcl_set = 1'b1;
                    eng_d   = ENG_IDLE;
                end else begin
                    st_d  = '0;
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_q == HALF_LAST) begin
                        cnt_d = '0;
                        if (bit_q == 4'd8) begin
                            nack_d = s2_q.sda;
                            eng_d  = ENG_HOLD;
                        end else begin
                            bit_d = bit_q + 4'd1;
                            sh_d  = {sh_q[6:0], 1'b0};
                            eng_d = ENG_LOW;
                        end
                    end
                end
            end
            default: eng_d = ENG_IDLE;
        endcase
        if (eng_d == ENG_IDLE) st_d = '0;
        // Receiver watches bus traffic while the host engine is quiet
        if (start_ev)
            rbit_d = '0;
        else if (scl_rise && s_q && eng_q == ENG_IDLE) begin
            if (rbit_q == 4'd8)
                rbit_d = '0;
            else begin
                rsh_d  = {rsh_q[6:0], s2_q.sda};
                rbit_d = rbit_q + 4'd1;
                if (rbit_q == 4'd7) begin
                    rx_set = 1'b1;
                    // A byte landing on the read that empties the holder is kept
                    if (rxf_q && !(rd && PADDR == `IESR_OFF_RXD))
                        ov_set = 1'b1;
                    else
                        rxb_d = {rsh_q[6:0], s2_q.sda};
                end
            end
        end
        if (!en_d) begin
            eng_d = ENG_IDLE;
            spend_d = 1'b0;
            ppend_d = 1'b0;
            tpend_d = 1'b0;
            rbit_d  = '0;
            cnt_d   = '0;
        end
        oe_d = drive(eng_d, bit_d, sh_d);
    end

    // Status flags: hardware set wins over a software clear
    always_comb begin
        s_d  = start_ev ? 1'b1 : (stop_ev ? 1'b0 : s_q);
        p_d  = stop_ev ? 1'b1 : (start_ev ? 1'b0 : p_q);
        bcl_d  = bcl_set | (bcl_q & ~(wr && PADDR == `IESR_OFF_STAT
                                      && PWDATA[`IESR_ST_BCL]));
        ov_d   = ov_set | (ov_q & ~(wr && PADDR == `IESR_OFF_STAT
                                    && PWDATA[`IESR_ST_OV]));
        halt_d = halt_set | (halt_q & ~(wr && PADDR == `IESR_OFF_STAT
                                        && PWDATA[`IESR_ST_HALT]));
        rxf_d  = rx_set | (rxf_q & ~(rd && PADDR == `IESR_OFF_RXD));
        ist_d  = {halt_set, rx_set, ov_set, bcl_set}
               | (ist_q & ~{4{rd && PADDR == `IESR_OFF_IST}});
        if (!en_d) begin
            // Whole status word drops with the enable
            {s_d, p_d, bcl_d, ov_d, halt_d, rxf_d, ist_d} = '0;
        end
        prd_d = '0;
        unique case (PADDR)
            `IESR_OFF_CTRL: begin
                prd_d[`IESR_CTRL_EN]   = en_q;
                prd_d[`IESR_CTRL_HOST] = host_q;
            end
            `IESR_OFF_STAT: begin
                prd_d[`IESR_ST_BUSY] = eng_q != ENG_IDLE;
                prd_d[`IESR_ST_RXF]  = rxf_q;
                prd_d[`IESR_ST_S]    = s_q;
                prd_d[`IESR_ST_P]    = p_q;
                prd_d[`IESR_ST_HALT] = halt_q;
                prd_d[`IESR_ST_NACK] = nack_q;
                prd_d[`IESR_ST_BCL]  = bcl_q;
                prd_d[`IESR_ST_OV]   = ov_q;
            end
            `IESR_OFF_TXD:  prd_d[7:0] = txb_q;
            `IESR_OFF_RXD:  prd_d[7:0] = rxb_q;
            `IESR_OFF_IST:  prd_d[3:0] = ist_q;
            `IESR_OFF_IMSK: prd_d[3:0] = imsk_q;
            default:        prd_d = '0;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            eng_q <= ENG_IDLE;
            {en_q, host_q, spend_q, ppend_q, tpend_q} <= '0;
            {s_q, p_q, bcl_q, ov_q, halt_q, nack_q, rxf_q} <= '0;
            {txb_q, sh_q, rsh_q, rxb_q} <= '0;
            {bit_q, rbit_q, ist_q, imsk_q, cnt_q, st_q} <= '0;
            oe_q   <= '0;
            PRDATA <= `IESR_RST_WORD;
        end else begin
            eng_q <= eng_d;
            {en_q, host_q, spend_q, ppend_q, tpend_q}
                <= {en_d, host_d, spend_d, ppend_d, tpend_d};
            {s_q, p_q, bcl_q, ov_q, halt_q, nack_q, rxf_q}
                <= {s_d, p_d, bcl_d, ov_d, halt_d, nack_d & en_d, rxf_d};
            {txb_q, sh_q, rsh_q, rxb_q} <= {txb_d, sh_d, rsh_d, rxb_d};
            {bit_q, rbit_q, ist_q, imsk_q, cnt_q, st_q}
                <= {bit_d, rbit_d, ist_d, imsk_d, cnt_d, st_d};
            oe_q <= oe_d;
            if (PSEL && !PENABLE) PRDATA <= prd_d;
        end
    end

    assign PREADY   = 1'b1;
    assign PSLVERR  = PSEL & PENABLE & ~hit;
    assign LINK_OUT = '0;
    assign LINK_OE  = oe_q;
    assign IRQ      = |(ist_q & imsk_q);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence busy_then_idle;
        !(eng_q inside {ENG_IDLE, ENG_STOPH}) ##1 eng_q == ENG_IDLE;
    endsequence

    a_dis_clears: assert property ($fell(en_q) |-> ##[0:3]
        (!bcl_q && !ov_q && !s_q && !p_q && !halt_q && !rxf_q && eng_q == ENG_IDLE))
        else $error("status not cleared after disable");
    a_bcl_host_only: assert property ($rose(bcl_q) |-> $past(host_q))
        else $error("collision flag set outside host mode");
    a_bcl_sticky: assert property (bcl_q && en_d && !(wr && PADDR == `IESR_OFF_STAT
        && PWDATA[`IESR_ST_BCL]) |=> bcl_q)
        else $error("collision flag lost");
    a_ov_sticky: assert property (ov_q && en_d && !(wr && PADDR == `IESR_OFF_STAT
        && PWDATA[`IESR_ST_OV]) |=> ov_q)
        else $error("overflow flag lost");
    a_ov_cause: assert property ($rose(ov_q) |-> $past(rxf_q && rx_set))
        else $error("overflow without unread byte");
    a_start_flag: assert property (start_ev && en_d |=> s_q && !p_q)
        else $error("start flag wrong");
    a_stop_flag: assert property (stop_ev && en_d |=> p_q && !s_q)
        else $error("stop flag wrong");
    a_start_taken: assert property (eng_q == ENG_IDLE && spend_q && host_q && !s_q
        && en_d |=> eng_q == ENG_START ##1 LINK_OE.sda && !LINK_OE.scl)
        else $error("start request not served");
    a_halt_reported: assert property (busy_then_idle |->
        (bcl_q || halt_q || !en_q))
        else $error("transfer halted silently");
endmodule // iesr_ctrl

//--- sim/iesr_bus_model.sv
// Far-side two-wire bus party: drives start, data bytes and stop
`timescale 1ns/1ps

module iesr_bus_model (
    output iesr_pkg::iesr_pins_t pull
);
    import iesr_pkg::*;

    // ------------------------------------------------------------
    // Line drivers
    // ------------------------------------------------------------
    // Open drain only: a released line floats to the pull-up level
    initial begin
        pull = '0;
    end

    // Skewed by 7 ns so link edges never sit on the block's clock edge
    task automatic start_cond();
        #7;
        pull.sda = 1'b1;
        #160;
        pull.scl = 1'b1;
        #160;
    endtask

    // Eight data bits MSB first, ninth clock with data released
    task automatic put_byte(input logic [7:0] b);
        #7;
        for (int i = 7; i >= -1; i--) begin
            pull.sda = (i >= 0) ? ~b[i] : 1'b0;
            #160;
            pull.scl = 1'b0;
            #160;
            pull.scl = 1'b1;
        end
    endtask

    // Rival party holding data low against the block, or letting it go
    task automatic hold_data(input logic v);
        #7;
        pull.sda = v;
    endtask

    task automatic stop_cond();
        #7;
        pull.sda = 1'b1;
        #160;
        pull.scl = 1'b0;
        #160;
        pull.sda = 1'b0;
        #160;
    endtask
endmodule // iesr_bus_model

//--- sim/tb.sv
// Self-checking bench for the two-wire error and recovery controller
`timescale 1ns/1ps
`include "iesr_consts.svh"

module tb;
    import iesr_pkg::*;

    logic        ref_clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    iesr_pins_t  link_in;
    iesr_pins_t  link_oe;
    iesr_pins_t  link_out;
    iesr_pins_t  pull;
    int          mismatches;
    int          checks_done;
    int          cycles;

    // ------------------------------------------------------------
    // Wires and instances
    // ------------------------------------------------------------
    assign link_in.scl = ~(link_oe.scl | pull.scl);
    assign link_in.sda = ~(link_oe.sda | pull.sda);

    iesr_ctrl #(.STRETCH_CYC(200)) dut (
        .REF_CLK  (ref_clk),
        .RST      (rst),
        .PSEL     (psel),
        .PENABLE  (penable),
        .PWRITE   (pwrite),
        .PADDR    (paddr),
        .PWDATA   (pwdata),
        .PRDATA   (prdata),
        .PREADY   (pready),
        .PSLVERR  (pslverr),
        .LINK_IN  (link_in),
        .LINK_OUT (link_out),
        .LINK_OE  (link_oe),
        .IRQ      (irq)
    );

    iesr_bus_model model (
        .pull (pull)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    // Status changes follow the link, so poll under a bound
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 400; i++) begin
            apb(1'b0, `IESR_OFF_STAT, 32'h0, r, e);
            if ((r & m) === v) break;
        end
        chk(r & m, v);
    endtask

    // ------------------------------------------------------------
    // Clock, reset, timeout
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Software transfer timeout; a hang ends the run as a failure
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic        e;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(`IESR_OFF_CTRL, 32'h0000_0000);
        rd_chk(`IESR_OFF_STAT, 32'h0000_0000);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk({r[30:0], e}, 32'h0000_0001);
        // Client reception, overflow and its recovery
        wr(`IESR_OFF_IMSK, 32'h0000_0002);
        wr(`IESR_OFF_CTRL, 32'h0000_8000);
        model.start_cond();
        poll(32'h0000_0008, 32'h0000_0008);
        model.put_byte(8'ha5);
        poll(32'h0000_0002, 32'h0000_0002);
        model.put_byte(8'h3c);
        poll(32'h0010_0000, 32'h0010_0000);
        chk({31'h0, irq}, 32'h0000_0001);
        rd_chk(`IESR_OFF_RXD, 32'h0000_00a5);
        model.put_byte(8'h5a);
        poll(32'h0010_0002, 32'h0010_0002);
        rd_chk(`IESR_OFF_RXD, 32'h0000_005a);
        wr(`IESR_OFF_STAT, 32'h0010_0000);
        model.put_byte(8'h81);
        poll(32'h0010_0002, 32'h0000_0002);
        rd_chk(`IESR_OFF_RXD, 32'h0000_0081);
        rd_chk(`IESR_OFF_IST, 32'h0000_0006);
        @(negedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        model.stop_cond();
        poll(32'h0000_0010, 32'h0000_0010);
        // Host start refused on a busy bus, then recovery
        wr(`IESR_OFF_CTRL, 32'h0000_8001);
        model.start_cond();
        wr(`IESR_OFF_CTRL, 32'h0000_8003);
        poll(32'h0000_0400, 32'h0000_0400);
        rd_chk(`IESR_OFF_CTRL, 32'h0000_8001);
        chk({31'h0, irq}, 32'h0000_0000);
        model.stop_cond();
        poll(32'h0000_0410, 32'h0000_0410);
        wr(`IESR_OFF_STAT, 32'h0000_0400);
        poll(32'h0000_0400, 32'h0000_0000);
        apb(1'b0, `IESR_OFF_CTRL, 32'h0, r, e);
        wr(`IESR_OFF_CTRL, r | 32'h0000_0002);
        poll(32'h0000_0009, 32'h0000_0009);
        chk({30'h0, link_in}, 32'h0000_0002);
        chk({30'h0, link_out}, 32'h0000_0000);
        wr(`IESR_OFF_CTRL, 32'h0000_8005);
        poll(32'h0000_0011, 32'h0000_0010);
        // Rival holds data low while the block sends a one
        wr(`IESR_OFF_CTRL, 32'h0000_8003);
        poll(32'h0000_0009, 32'h0000_0009);
        model.hold_data(1'b1);
        wr(`IESR_OFF_TXD, 32'h0000_0080);
        poll(32'h0000_0401, 32'h0000_0400);
        chk({30'h0, link_oe}, 32'h0000_0000);
        model.hold_data(1'b0);
        poll(32'h0000_0410, 32'h0000_0410);
        wr(`IESR_OFF_STAT, 32'h0000_0400);
        // Disable clears status, enable resumes from clean state
        model.start_cond();
        wr(`IESR_OFF_CTRL, 32'h0000_8003);
        poll(32'h0000_0400, 32'h0000_0400);
        wr(`IESR_OFF_CTRL, 32'h0000_0000);
        rd_chk(`IESR_OFF_STAT, 32'h0000_0000);
        model.stop_cond();
        wr(`IESR_OFF_CTRL, 32'h0000_8000);
        rd_chk(`IESR_OFF_STAT, 32'h0000_0000);
        model.start_cond();
        model.put_byte(8'hc3);
        poll(32'h0000_0002, 32'h0000_0002);
        rd_chk(`IESR_OFF_RXD, 32'h0000_00c3);
        model.stop_cond();
        wrap_up();
    end
endmodule // tb
